// ==== shared/ccr_pkg.sv ====
// constants shared by the clock gate and synthesizer output route block
package ccr_pkg;
  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_REFSEL = 8'h04;
  localparam logic [7:0] REG_NDIV = 8'h08;
  localparam logic [7:0] REG_MDIV = 8'h0c;
  localparam logic [7:0] REG_CDIV0 = 8'h10;
  localparam logic [7:0] REG_STEP = 8'h04;
  localparam logic [7:0] REG_NETCFG = 8'h2c;
  localparam logic [7:0] REG_EXTCFG = 8'h30;
  localparam logic [7:0] REG_STATUS = 8'h34;
  // synthesizer figures
  localparam int NUM_CNT = 7;
  localparam int DIV_W = 10;
  localparam int CNT_W = 9;
  localparam int PHASE_W = 3;
  localparam int SRC_W = 4;
  localparam logic [DIV_W-1:0] DIV_MIN = 10'h001;
  localparam logic [DIV_W-1:0] DIV_MAX = 10'h200;
  localparam logic [DIV_W-1:0] DIV_RST = 10'h001;
  localparam logic [PHASE_W-1:0] OSC_LAST = 3'h7;
  localparam logic [SRC_W-1:0] SRC_PIN0 = 4'h8;
  // field positions
  localparam int CTRL_LOCK_BIT = 0;
  localparam int REF_KIND_LSB = 0;
  localparam int REF_IDX_LSB = 2;
  localparam int CDIV_DIV_LSB = 0;
  localparam int CDIV_PHASE_LSB = 16;
  localparam int NET_FIELD_W = 5;
  localparam int NET_BYPASS_POS = 4;
  localparam int EXT_SRC_LSB = 0;
  localparam int EXT_USE_BIT = 3;
  localparam int EXT_DIFF_BIT = 4;
  localparam int EXT_PAIR_LSB = 5;
  localparam int EXT_INVP_BIT = 7;
  localparam int EXT_INVN_BIT = 8;
  localparam int ST_LOCK_BIT = 0;
  localparam int ST_FB_BIT = 1;
  localparam int ST_REFDIV_BIT = 2;
  localparam int ST_EXTEN_BIT = 3;
  localparam int ST_NETEN_LSB = 4;
  // reference source kinds
  localparam logic [1:0] REF_PIN = 2'h0;
  localparam logic [1:0] REF_NET = 2'h1;
  localparam logic [1:0] REF_NEIGHBOUR = 2'h2;
endpackage

// ==== hw/ccr_top.sv ====
// clock network gates and synthesizer output routing behind an ahb-lite slave
//
// The register addresses and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/10ps
module ccr_top
  import ccr_pkg::*;
#(
  parameter int unsigned NUM_NET = 4,
  parameter int unsigned NUM_PAIRS = 3
)
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // reference sources
  input wire logic [3:0] ref_pin_clk,
  input wire logic neighbour_in,
  output logic synth_cascade_out,
  // network gates
  input wire logic [NUM_NET-1:0] net_clkena,
  output logic [NUM_NET-1:0] global_clock_network,
  // external clock output gate
  input wire logic ext_clkena,
  // external clock pins, two-way when used as user i/o
  input wire logic [NUM_PAIRS-1:0] ext_clock_in_pos,
  input wire logic [NUM_PAIRS-1:0] ext_clock_in_neg,
  output logic [NUM_PAIRS-1:0] ext_clock_out_pos,
  output logic [NUM_PAIRS-1:0] ext_clock_out_pos_oe,
  output logic [NUM_PAIRS-1:0] ext_clock_out_neg,
  output logic [NUM_PAIRS-1:0] ext_clock_out_neg_oe,
  // user i/o sharing those pins
  input wire logic [NUM_PAIRS-1:0] user_pos_out,
  input wire logic [NUM_PAIRS-1:0] user_pos_oe,
  input wire logic [NUM_PAIRS-1:0] user_neg_out,
  input wire logic [NUM_PAIRS-1:0] user_neg_oe,
  output logic [NUM_PAIRS-1:0] user_pos_in,
  output logic [NUM_PAIRS-1:0] user_neg_in
);

  if (NUM_NET < 1 || NUM_NET > 4)
  begin : g_chk_net
    $error("NUM_NET must lie in 1..4");
  end
  if (NUM_PAIRS < 1 || NUM_PAIRS > 4)
  begin : g_chk_pairs
    $error("NUM_PAIRS must lie in 1..4");
  end

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [31:0] rdata;
    logic lock;
    logic [1:0] ref_kind;
    logic [1:0] ref_idx;
    logic [DIV_W-1:0] ndiv;
    logic [DIV_W-1:0] mdiv;
    logic [NUM_CNT-1:0][DIV_W-1:0] cdiv;
    logic [NUM_CNT-1:0][PHASE_W-1:0] cphase;
    logic [NUM_NET-1:0][SRC_W-1:0] net_src;
    logic [NUM_NET-1:0] net_bypass;
    logic [2:0] ext_src;
    logic ext_use;
    logic ext_diff;
    logic [1:0] ext_pair;
    logic ext_invp;
    logic ext_invn;
    logic [PHASE_W-1:0] osc_phase;
    logic [NUM_CNT:0][CNT_W-1:0] cnt;
    logic [NUM_CNT:0] wave;
    logic [CNT_W-1:0] ncnt;
    logic ref_prev;
    logic ref_div;
    logic [NUM_NET-1:0] net_s1;
    logic [NUM_NET-1:0] net_s2;
    logic [NUM_NET-1:0] net_prev;
    logic [NUM_NET-1:0] net_en;
    logic [NUM_NET-1:0] net_out;
    logic ext_s1;
    logic ext_s2;
    logic ext_prev;
    logic ext_en;
    logic ext_gated;
    logic [NUM_PAIRS-1:0] pos;
    logic [NUM_PAIRS-1:0] pos_oe;
    logic [NUM_PAIRS-1:0] neg;
    logic [NUM_PAIRS-1:0] neg_oe;
  } ccr_state_t;

  ccr_state_t s;
  ccr_state_t next_s;

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    logic [31:0] rd;
    logic [DIV_W-1:0] d;
    logic [PHASE_W-1:0] ph;
    logic [PHASE_W-1:0] sub;
    logic [CNT_W+PHASE_W-1:0] pos_in_period;
    logic src;
    logic ref_lvl;
    logic sel;
    logic clk_p;
    rd = 32'h0000_0000;
    d = DIV_RST;
    ph = '0;
    sub = '0;
    pos_in_period = '0;
    src = 1'b0;
    ref_lvl = 1'b0;
    sel = 1'b0;
    clk_p = 1'b0;
    next_s = s;

    // data phase of a write; config is frozen once locked
    if (s.wr)
    begin
      if (s.addr == REG_CTRL && hwdata[CTRL_LOCK_BIT])
        next_s.lock = 1'b1;
      if (!s.lock)
      begin
        if (s.addr == REG_REFSEL)
        begin
          next_s.ref_kind = hwdata[REF_KIND_LSB +: 2];
          next_s.ref_idx = hwdata[REF_IDX_LSB +: 2];
        end
        d = hwdata[CDIV_DIV_LSB +: DIV_W];
        // out-of-range divide values are dropped, old value kept
        if (d >= DIV_MIN && d <= DIV_MAX)
        begin
          if (s.addr == REG_NDIV)
            next_s.ndiv = d;
          if (s.addr == REG_MDIV)
            next_s.mdiv = d;
        end
        for (int i = 0; i < NUM_CNT; i++)
        begin
          if (s.addr == 8'(REG_CDIV0 + REG_STEP * 8'(i)))
          begin
            next_s.cphase[i] = hwdata[CDIV_PHASE_LSB +: PHASE_W];
            if (d >= DIV_MIN && d <= DIV_MAX)
              next_s.cdiv[i] = d;
          end
        end
        if (s.addr == REG_NETCFG)
        begin
          for (int i = 0; i < NUM_NET; i++)
          begin
            next_s.net_src[i] = hwdata[NET_FIELD_W*i +: SRC_W];
            next_s.net_bypass[i] = hwdata[NET_FIELD_W*i + NET_BYPASS_POS];
          end
        end
        if (s.addr == REG_EXTCFG)
        begin
          next_s.ext_src = hwdata[EXT_SRC_LSB +: 3];
          next_s.ext_use = hwdata[EXT_USE_BIT];
          next_s.ext_diff = hwdata[EXT_DIFF_BIT];
          next_s.ext_pair = hwdata[EXT_PAIR_LSB +: 2];
          next_s.ext_invp = hwdata[EXT_INVP_BIT];
          next_s.ext_invn = hwdata[EXT_INVN_BIT];
        end
      end
    end

    // address phase; read data is registered for the data phase
    next_s.wr = hsel && hready && htrans[1] && hwrite;
    next_s.addr = haddr[7:0];
    case (haddr[7:0])
      REG_CTRL: rd[CTRL_LOCK_BIT] = s.lock;
      REG_REFSEL:
      begin
        rd[REF_KIND_LSB +: 2] = s.ref_kind;
        rd[REF_IDX_LSB +: 2] = s.ref_idx;
      end
      REG_NDIV: rd[CDIV_DIV_LSB +: DIV_W] = s.ndiv;
      REG_MDIV: rd[CDIV_DIV_LSB +: DIV_W] = s.mdiv;
      REG_NETCFG:
        for (int i = 0; i < NUM_NET; i++)
        begin
          rd[NET_FIELD_W*i +: SRC_W] = s.net_src[i];
          rd[NET_FIELD_W*i + NET_BYPASS_POS] = s.net_bypass[i];
        end
      REG_EXTCFG:
      begin
        rd[EXT_SRC_LSB +: 3] = s.ext_src;
        rd[EXT_USE_BIT] = s.ext_use;
        rd[EXT_DIFF_BIT] = s.ext_diff;
        rd[EXT_PAIR_LSB +: 2] = s.ext_pair;
        rd[EXT_INVP_BIT] = s.ext_invp;
        rd[EXT_INVN_BIT] = s.ext_invn;
      end
      REG_STATUS:
      begin
        rd[ST_LOCK_BIT] = s.lock;
        rd[ST_FB_BIT] = s.wave[NUM_CNT];
        rd[ST_REFDIV_BIT] = s.ref_div;
        rd[ST_EXTEN_BIT] = s.ext_en;
        rd[ST_NETEN_LSB +: NUM_NET] = s.net_en;
      end
      default:
        for (int i = 0; i < NUM_CNT; i++)
        begin
          if (haddr[7:0] == 8'(REG_CDIV0 + REG_STEP * 8'(i)))
          begin
            rd[CDIV_DIV_LSB +: DIV_W] = s.cdiv[i];
            rd[CDIV_PHASE_LSB +: PHASE_W] = s.cphase[i];
          end
        end
    endcase
    if (hsel && hready && htrans[1] && !hwrite)
      next_s.rdata = rd;

    // oscillator: eight hclk cycles per period, one cycle per phase step
    next_s.osc_phase = s.osc_phase + 1'b1;
    // counters 0..6 are outputs, the last one is the feedback counter;
    // no enable input reaches them, so gating cannot upset the loop
    for (int k = 0; k <= NUM_CNT; k++)
    begin
      d = (k < NUM_CNT) ? s.cdiv[k % NUM_CNT] : s.mdiv;
      ph = (k < NUM_CNT) ? s.cphase[k % NUM_CNT] : '0;
      sub = PHASE_W'(s.osc_phase - ph);
      if (sub == OSC_LAST)
        next_s.cnt[k] = (s.cnt[k] >= CNT_W'(d - 1'b1)) ? '0 :
                        s.cnt[k] + 1'b1;
      pos_in_period = {s.cnt[k], sub};
      // period is 8*d cycles, high for the first half
      next_s.wave[k] = pos_in_period < {d, 2'b00};
    end

    // reference mux and divider
    case (s.ref_kind)
      REF_PIN: ref_lvl = ref_pin_clk[s.ref_idx];
      REF_NET: ref_lvl = (32'(s.ref_idx) < NUM_NET) ?
                         s.net_out[s.ref_idx] : 1'b0;
      REF_NEIGHBOUR: ref_lvl = neighbour_in;
      default: ref_lvl = 1'b0;
    endcase
    next_s.ref_prev = ref_lvl;
    if (ref_lvl && !s.ref_prev)
    begin
      if (s.ncnt >= CNT_W'(s.ndiv - 1'b1))
      begin
        next_s.ncnt = '0;
        next_s.ref_div = !s.ref_div;
      end
      else
        next_s.ncnt = s.ncnt + 1'b1;
    end

    // network gates; sources may be pins, so no synthesizer is needed
    next_s.net_s1 = net_clkena;
    next_s.net_s2 = s.net_s1;
    for (int i = 0; i < NUM_NET; i++)
    begin
      if (s.net_src[i] < SRC_PIN0)
        src = s.wave[s.net_src[i][2:0]];
      else
        src = ref_pin_clk[s.net_src[i][1:0]];
      next_s.net_prev[i] = src;
      // enable moves only as the clock falls, so no pulse is cut short
      if (s.net_prev[i] && !src)
        next_s.net_en[i] = s.net_bypass[i] ? net_clkena[i] :
                           s.net_s2[i];
      next_s.net_out[i] = src && next_s.net_en[i];
    end

    // external output gate: both enable stages always in use
    next_s.ext_s1 = ext_clkena;
    next_s.ext_s2 = s.ext_s1;
    src = s.wave[s.ext_src];
    next_s.ext_prev = src;
    if (s.ext_prev && !src)
      next_s.ext_en = s.ext_s2;
    next_s.ext_gated = src && next_s.ext_en;

    // pin routing; one selected counter may reach every pin,
    // but only one pair carries it at a time
    for (int p = 0; p < NUM_PAIRS; p++)
    begin
      sel = s.ext_use && (32'(s.ext_pair) == p);
      clk_p = s.ext_gated ^ s.ext_invp;
      next_s.pos[p] = sel ? clk_p : user_pos_out[p];
      next_s.pos_oe[p] = sel ? 1'b1 : user_pos_oe[p];
      if (sel && s.ext_diff)
      begin
        next_s.neg[p] = clk_p ^ s.ext_invn;
        next_s.neg_oe[p] = 1'b1;
      end
      else
      begin
        // single-ended leaves the negative pin to the user
        next_s.neg[p] = user_neg_out[p];
        next_s.neg_oe[p] = user_neg_oe[p];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s <= '0;
      s.ndiv <= DIV_RST;
      s.mdiv <= DIV_RST;
      s.cdiv <= {NUM_CNT{DIV_RST}};
    end
    else
      s <= next_s;
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  // zero wait states, always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s.rdata;
  assign synth_cascade_out = s.wave[0];
  assign global_clock_network = s.net_out;
  assign ext_clock_out_pos = s.pos;
  assign ext_clock_out_pos_oe = s.pos_oe;
  assign ext_clock_out_neg = s.neg;
  assign ext_clock_out_neg_oe = s.neg_oe;
  assign user_pos_in = ext_clock_in_pos;
  assign user_neg_in = ext_clock_in_neg;

endmodule

// ==== testbench/ccr_chk.sv ====
// port assertions for the clock gate and output route block
`timescale 1ns/10ps
module ccr_chk
  import ccr_pkg::*;
#(
  parameter int unsigned NUM_NET = 4,
  parameter int unsigned NUM_PAIRS = 3
)
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // watched outputs and inputs
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic synth_cascade_out,
  input wire logic [NUM_NET-1:0] net_clkena,
  input wire logic [NUM_NET-1:0] global_clock_network,
  input wire logic [NUM_PAIRS-1:0] ext_clock_in_pos,
  input wire logic [NUM_PAIRS-1:0] user_pos_in,
  input wire logic [NUM_PAIRS-1:0] ext_clock_out_pos
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  ////////////////////////////////////////////////////////////////////////////
  // cycles that network 0 has seen its enable low, saturating
  logic [3:0] off_cnt;
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      off_cnt <= 4'h0;
    else if (net_clkena[0])
      off_cnt <= 4'h0;
    else if (off_cnt != 4'hf)
      off_cnt <= off_cnt + 4'h1;
  ////////////////////////////////////////////////////////////////////////////
  bus_ready_a: assert property (hreadyout)
    else $error("slave inserted a wait state");
  bus_okay_a: assert property (!hresp)
    else $error("slave answered with an error");
  pin_in_copy_a: assert property (user_pos_in == ext_clock_in_pos)
    else $error("pin input not passed to user");
  cascade_free_a: assert property ($fell(synth_cascade_out) |->
    !synth_cascade_out[*4] ##1 synth_cascade_out[*4] ##1 !synth_cascade_out)
    else $error("counter wave disturbed");
  gate_high_a: assert property ($rose(global_clock_network[0]) |->
    global_clock_network[0][*4] ##1 !global_clock_network[0])
    else $error("gated pulse not full width");
  gate_low_a: assert property ($fell(global_clock_network[0]) |->
    !global_clock_network[0][*4])
    else $error("gated low phase cut short");
  // the gate lags the counter wave by a register or two, never more
  gate_src_a: assert property (global_clock_network[0] |->
    synth_cascade_out || $past(synth_cascade_out) ||
    $past(synth_cascade_out, 2))
    else $error("gated clock high without source");
  gate_off_a: assert property (off_cnt >= 4'hd |->
    !global_clock_network[0])
    else $error("disabled network still toggles");
  cover property ($rose(global_clock_network[0]));
  cover property (off_cnt == 4'hd);
  cover property ($rose(ext_clock_out_pos[1]));
endmodule
bind ccr_top ccr_chk #(.NUM_NET(NUM_NET), .NUM_PAIRS(NUM_PAIRS)) u_chk (
  .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
  .synth_cascade_out(synth_cascade_out), .net_clkena(net_clkena),
  .global_clock_network(global_clock_network),
  .ext_clock_in_pos(ext_clock_in_pos), .user_pos_in(user_pos_in),
  .ext_clock_out_pos(ext_clock_out_pos));

// ==== testbench/ccr_fabric.sv ====
// model of fabric logic driving the clock enables
`timescale 1ns/10ps
module ccr_fabric
(
  // clock and command
  input wire logic hclk,
  input wire logic [4:0] want,
  // enables toward the block
  output logic [3:0] net_clkena,
  output logic ext_clkena
);
  int skew = 3;
  initial {ext_clkena, net_clkena} = 5'h00;
  // fabric is not timed to the gated clock, so edges land anywhere
  always @(posedge hclk)
  begin
    skew = 3 + (skew * 7) % 15;
    #(skew) {ext_clkena, net_clkena} = want;
  end
endmodule

// ==== testbench/ccr_top_tb.sv ====
// self-checking bench for the clock gate and output route block
`timescale 1ns/10ps
module ccr_top_tb;
  import ccr_pkg::*;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, uchk = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd, rnd = 0, v;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, synth_cascade_out, ext_clkena;
  logic neighbour_in = 0;
  logic [3:0] ref_pin_clk = 0, net_clkena, global_clock_network;
  logic [4:0] want = 0;
  logic [2:0] user_pos_out = 0, user_pos_oe = 0;
  logic [2:0] user_neg_out = 0, user_neg_oe = 0;
  logic [2:0] ext_clock_in_pos, ext_clock_in_neg, user_pos_in, user_neg_in;
  logic [2:0] ext_clock_out_pos, ext_clock_out_pos_oe;
  logic [2:0] ext_clock_out_neg, ext_clock_out_neg_oe, watch;
  logic [9:0] pu;
  logic [5:0] hist;
  logic [31:0] ediv [9];
  int n_mismatch = 0, checks = 0, seed = 32'h3582, cyc = 0, c;
  always #10 hclk = ~hclk;
  // undriven pins show the inverse of the value on the output
  assign ext_clock_in_pos = ext_clock_out_pos ^ ~ext_clock_out_pos_oe;
  assign ext_clock_in_neg = ext_clock_out_neg ^ ~ext_clock_out_neg_oe;
  assign watch = {ext_clock_out_pos[1], global_clock_network[1:0]};
  ccr_top DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .ref_pin_clk,
    .neighbour_in, .synth_cascade_out, .net_clkena, .global_clock_network,
    .ext_clkena, .ext_clock_in_pos, .ext_clock_in_neg, .ext_clock_out_pos,
    .ext_clock_out_pos_oe, .ext_clock_out_neg, .ext_clock_out_neg_oe,
    .user_pos_out, .user_pos_oe, .user_neg_out, .user_neg_oe, .user_pos_in,
    .user_neg_in);
  ccr_fabric u_fab (.hclk, .want, .net_clkena, .ext_clkena);
  ////////////////////////////////////////////////////////////////////////////
  task end_sim;
    if (n_mismatch == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [31:0] div_keep(input logic [31:0] old, nv);
    return (nv[9:0] >= DIV_MIN && nv[9:0] <= DIV_MAX) ? 32'(nv[9:0]) : old;
  endfunction
  function automatic logic [31:0] exp_rises(input int div, input int n);
    return 32'(n / (8 * div));
  endfunction
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= 32'(a);
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  task rd_chk(input logic [7:0] a, input logic [31:0] e);
    bus(0, a, 0);
    chk(rd, e);
  endtask
  task count(input int k, input int n);
    logic p;
    p = watch[k];
    c = 0;
    repeat (n)
    begin
      @(negedge hclk);
      c += int'(watch[k] && !p);
      p = watch[k];
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge hclk)
  begin
    cyc <= cyc + 1;
    rnd <= $random(seed);
    ref_pin_clk <= $random(seed);
    {user_pos_out, user_neg_out, user_pos_oe, user_neg_oe} <= $random(seed);
    if (cyc % 24 == 0)
      neighbour_in <= ~neighbour_in;
    pu <= {user_neg_out, user_neg_oe, user_pos_out[0], user_pos_out[2],
      user_pos_oe[0], user_pos_oe[2]};
    if (cyc == 6000)
    begin
      n_mismatch++;
      end_sim;
    end
  end
  always @(negedge hclk)
  begin
    if (uchk)
      chk(32'({ext_clock_out_neg, ext_clock_out_neg_oe,
        ext_clock_out_pos[0], ext_clock_out_pos[2], ext_clock_out_pos_oe[0],
        ext_clock_out_pos_oe[2]}), 32'(pu));
    chk(32'(user_neg_in), 32'(ext_clock_in_neg));
  end
  initial
  begin
    repeat (20) @(posedge hclk);
    hresetn <= 1;
    chk(32'(global_clock_network), 0);
    rd_chk(REG_CTRL, 0);
    rd_chk(8'h38, 0);
    // dividers: upper bound, refused values, then a random legal value
    for (int i = 0; i < 9; i++)
    begin
      ediv[i] = 32'(DIV_RST);
      if (i == 2)
        continue;
      rd_chk(REG_NDIV + 8'(4 * i), ediv[i]);
      for (int j = 0; j < 4; j++)
      begin
        v = (j == 0) ? 32'h0000_0200 : (j == 1) ? 0 : 32'h0000_0201;
        if (j == 3)
          v = 32'(rnd[8:0]) + 1;
        bus(1, REG_NDIV + 8'(4 * i), v);
        ediv[i] = div_keep(ediv[i], v);
      end
    end
    for (int i = 0; i < 9; i++)
      rd_chk(REG_NDIV + 8'(4 * i), ediv[i]);
    for (int k = 3; k >= 0; k--)
    begin
      v = 32'({rnd[1:0], 2'(k)});
      bus(1, REG_REFSEL, v);
      rd_chk(REG_REFSEL, v);
    end
    // network 1 bypasses the synchroniser, network 0 keeps it
    bus(1, REG_NETCFG, 32'h0000_0200);
    want <= 5'h1f;
    repeat (16) @(posedge hclk);
    count(0, 64);
    chk(32'(c), exp_rises(1, 64));
    want <= 5'h1e;
    repeat (16) @(posedge hclk);
    count(0, 64);
    chk(32'(c), 0);
    count(1, 64);
    chk(32'(c), exp_rises(1, 64));
    // feedback counter on pair 1, single ended
    bus(1, REG_MDIV, 2);
    bus(1, REG_EXTCFG, 32'h0000_002f);
    repeat (4) @(posedge hclk);
    uchk <= 1;
    count(2, 64);
    chk(32'(c), exp_rises(2, 64));
    chk(32'(ext_clock_out_pos_oe[1]), 1);
    want <= 5'h0e;
    repeat (16) @(posedge hclk);
    count(2, 64);
    chk(32'(c), 0);
    uchk <= 0;
    bus(1, REG_EXTCFG, 32'h0000_013f);
    want <= 5'h1e;
    repeat (16) @(posedge hclk);
    repeat (16)
    begin
      @(negedge hclk);
      chk(32'({ext_clock_out_neg[1], ext_clock_out_neg_oe[1]}),
        32'({~ext_clock_out_pos[1], 1'b1}));
    end
    bus(1, REG_EXTCFG, 0);
    repeat (4) @(posedge hclk);
    uchk <= 1;
    repeat (32) @(posedge hclk);
    uchk <= 0;
    // c1 five phase steps late: network 2 trails network 1 by five cycles
    bus(1, REG_CDIV0 + REG_STEP, 32'h0005_0001);
    rd_chk(REG_CDIV0 + REG_STEP, 32'h0005_0001);
    bus(1, REG_NETCFG, 32'h0000_0600);
    repeat (16) @(posedge hclk);
    hist = 0;
    for (int n = 0; n < 24; n++)
    begin
      @(negedge hclk);
      hist = {hist[4:0], global_clock_network[1]};
      if (n >= 5)
        chk(32'(global_clock_network[2]), 32'(hist[5]));
    end
    // locking freezes the static selects
    bus(1, REG_CTRL, 1);
    bus(1, REG_REFSEL, 32'h0000_0006);
    rd_chk(REG_REFSEL, v);
    bus(1, REG_NDIV, 5);
    rd_chk(REG_NDIV, ediv[0]);
    rd_chk(REG_CTRL, 1);
    // status: locked, external gate on, networks 1..3 on, network 0 off
    bus(0, REG_STATUS, 0);
    chk(rd & 32'h0000_00f9, 32'h0000_00e9);
    end_sim;
  end
endmodule
